// File: pkg/cbx_defines.svh
// register offsets, field positions, reset values and cycle counts of the execution unit
`ifndef CBX_DEFINES_SVH
`define CBX_DEFINES_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CBX_ADDR_INSTR 8'h00
`define CBX_ADDR_STATUS 8'h04
`define CBX_ADDR_FLAGS 8'h08
`define CBX_ADDR_PC 8'h0c
`define CBX_ADDR_SP 8'h10
`define CBX_ADDR_GPR 8'h80

// ----------------------------------------
// reset values
// ----------------------------------------
`define CBX_FLAGS_RST 8'h00
`define CBX_PC_RST 16'h0000
`define CBX_SP_RST 16'h00ff

// ----------------------------------------
// status_flags bit positions
// ----------------------------------------
`define CBX_FLAG_C 0
`define CBX_FLAG_Z 1
`define CBX_FLAG_N 2
`define CBX_FLAG_V 3
`define CBX_FLAG_S 4
`define CBX_FLAG_H 5
`define CBX_FLAG_T 6
`define CBX_FLAG_I 7

// ----------------------------------------
// status register fields
// ----------------------------------------
`define CBX_ST_BUSY 0
`define CBX_ST_ERR 1
`define CBX_ST_CYC_LO 4
`define CBX_ST_CYC_HI 5

// ----------------------------------------
// pointer registers, low byte index; r0 and r1
// ----------------------------------------
`define CBX_R_XL 5'd26
`define CBX_R_YL 5'd28
`define CBX_R_ZL 5'd30
`define CBX_R_R0 5'd0
`define CBX_R_R1 5'd1

// ----------------------------------------
// pointer selects and update modes
// ----------------------------------------
`define CBX_PTR_X 2'h0
`define CBX_PTR_Y 2'h1
`define CBX_PTR_Z 2'h2
`define CBX_MODE_PLAIN 2'h0
`define CBX_MODE_INC 2'h1
`define CBX_MODE_DEC 2'h2

// ----------------------------------------
// cycle counts
// ----------------------------------------
`define CBX_LEN_1 2'd1
`define CBX_LEN_2 2'd2
`define CBX_LEN_3 2'd3

`endif

// File: pkg/cbx_pkg.sv
// types shared by the execution unit and its shifter
package cbx_pkg;

	// ----------------------------------------
	// operation codes
	// ----------------------------------------
	typedef enum logic [4:0] {
		CBX_OP_NOP = 5'h00,
		CBX_OP_SLEEP = 5'h01,
		CBX_OP_WDR = 5'h02,
		CBX_OP_BREAK = 5'h03,
		CBX_OP_BR_FSET = 5'h04,
		CBX_OP_BR_FCLR = 5'h05,
		CBX_OP_BR_GE = 5'h06,
		CBX_OP_BR_LT = 5'h07,
		CBX_OP_IO_SET = 5'h08,
		CBX_OP_IO_CLR = 5'h09,
		CBX_OP_LSL = 5'h0a,
		CBX_OP_LSR = 5'h0b,
		CBX_OP_ROL = 5'h0c,
		CBX_OP_ROR = 5'h0d,
		CBX_OP_ASR = 5'h0e,
		CBX_OP_BST = 5'h0f,
		CBX_OP_BLD = 5'h10,
		CBX_OP_FSET = 5'h11,
		CBX_OP_FCLR = 5'h12,
		CBX_OP_LD_IND = 5'h13,
		CBX_OP_ST_IND = 5'h14,
		CBX_OP_LD_DISP = 5'h15,
		CBX_OP_ST_DISP = 5'h16,
		CBX_OP_LD_DIR = 5'h17,
		CBX_OP_ST_DIR = 5'h18,
		CBX_OP_PM_READ = 5'h19,
		CBX_OP_PM_WRITE = 5'h1a,
		CBX_OP_PUSH = 5'h1b,
		CBX_OP_POP = 5'h1c
	} cbx_op_e;

	typedef enum logic [0:0] {
		CBX_ST_IDLE = 1'b0,
		CBX_ST_EXEC = 1'b1
	} cbx_state_e;

	// instruction word as written by software
	typedef struct packed {
		logic [15:0] imm;
		logic spare;
		logic [1:0] mode;
		logic [2:0] sel;
		logic [4:0] rd;
		logic [4:0] op;
	} cbx_instr_s;

	typedef struct packed {
		logic re;
		logic we;
		logic [15:0] addr;
		logic [7:0] wdata;
	} cbx_mem_req_s;

	typedef struct packed {
		logic re;
		logic we;
		logic [5:0] addr;
		logic [7:0] wdata;
	} cbx_io_req_s;

	typedef struct packed {
		logic re;
		logic we;
		logic [14:0] addr;
		logic [15:0] wdata;
	} cbx_pm_req_s;

endpackage

// File: design/cbx_shift_unit.sv
// one-cycle shifter and rotator with its flag results
`timescale 1ns/10ps

module cbx_shift_unit (
	input cbx_pkg::cbx_op_e op,
	input logic [7:0] value,
	input logic cin,
	output logic [7:0] result,
	output logic c_out,
	output logic z_out,
	output logic n_out,
	output logic v_out
);

	// --------------------------------
	// shift and rotate
	// --------------------------------
	always_comb begin
		result = value;
		c_out = value[0];
		case (op)
			cbx_pkg::CBX_OP_LSL: begin
				result = {value[6:0], 1'b0};
				c_out = value[7];
			end
			cbx_pkg::CBX_OP_LSR: result = {1'b0, value[7:1]};
			cbx_pkg::CBX_OP_ROL: begin
				result = {value[6:0], cin};
				c_out = value[7];
			end
			cbx_pkg::CBX_OP_ROR: result = {cin, value[7:1]};
			cbx_pkg::CBX_OP_ASR: result = {value[7], value[7:1]}; // sign bit kept
			default: result = value;
		endcase
	end

	// flags follow the shifted value
	assign z_out = (result == 8'h00);
	assign n_out = result[7];
	assign v_out = result[7] ^ c_out;

endmodule

// File: design/cbx_core.sv
// branch, bit-operation and data-transfer execution unit behind an ahb-lite port
//
// The register addresses and the AHB-Lite register port were left to the implementer.
`timescale 1ns/10ps
`include "cbx_defines.svh"
// ------------------------------------------------------------------
// ------------------------------------------------------------------

module cbx_core (
	input logic hclk,
	input logic hresetn,
	input logic hsel,
	input logic [31:0] haddr,
	input logic [1:0] htrans,
	input logic hwrite,
	input logic [2:0] hsize,
	input logic [31:0] hwdata,
	input logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output cbx_pkg::cbx_mem_req_s dmem_req,
	input logic [7:0] dmem_rdata,
	output cbx_pkg::cbx_io_req_s io_req,
	input logic [7:0] io_rdata,
	output cbx_pkg::cbx_pm_req_s pm_req,
	input logic [15:0] pm_rdata,
	output logic sleep_req,
	output logic wdr_pulse,
	output logic break_pulse
);

	logic wr_pend_reg;
	logic [7:0] wr_addr_reg;
	logic [31:0] hrdata_reg;
	cbx_pkg::cbx_state_e st_reg;
	logic [1:0] step_reg;
	cbx_pkg::cbx_instr_s ins_reg;
	logic err_reg;
	logic [1:0] cyc_reg;
	logic [7:0] gpr_reg [32];
	logic [7:0] flags_reg;
	logic [15:0] pc_reg;
	logic [15:0] sp_reg;
	logic [15:0] pm_hold_reg;
	cbx_pkg::cbx_op_e op;
	logic busy;
	logic wr_ok;
	logic [1:0] len_c;
	logic bad_c;
	logic take_c;
	logic last_c;
	logic step0;
	logic [4:0] pidx;
	logic [15:0] ptr_val;
	logic [15:0] ea_c;
	logic [7:0] rd_val;
	logic [7:0] bmask;
	logic [7:0] sh_res;
	logic sh_c;
	logic sh_z;
	logic sh_n;
	logic sh_v;
	logic gwe_c;
	logic [4:0] gwa_c;
	logic [7:0] gwd_c;
	logic pwe_c;
	logic [15:0] pwd_c;
	logic [7:0] flags_next;
	logic [15:0] sp_next;
	logic [31:0] rdmux_c;

	assign op = cbx_pkg::cbx_op_e'(ins_reg.op);
	assign busy = (st_reg == cbx_pkg::CBX_ST_EXEC);
	assign hreadyout = 1'b1; // zero wait states
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;
	assign wr_ok = wr_pend_reg && !busy;
	assign step0 = busy && (step_reg == 2'd0);
	assign last_c = busy && (step_reg == len_c - 2'd1);

	// --------------------------------
	// bus slave
	// --------------------------------
	// address phase capture for writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end else if (hready) begin
			wr_pend_reg <= hsel && htrans[1] && hwrite;
			wr_addr_reg <= haddr[7:0];
		end
	end

	// read mux, sampled in the address phase
	always_comb begin
		rdmux_c = 32'h0000_0000;
		if (haddr[7:0] >= `CBX_ADDR_GPR) begin
			rdmux_c = {24'h00_0000, gpr_reg[haddr[6:2]]};
		end else begin
			case (haddr[7:0])
				`CBX_ADDR_INSTR: rdmux_c = ins_reg;
				`CBX_ADDR_STATUS: begin
					rdmux_c[`CBX_ST_BUSY] = busy;
					rdmux_c[`CBX_ST_ERR] = err_reg;
					rdmux_c[`CBX_ST_CYC_HI:`CBX_ST_CYC_LO] = cyc_reg;
				end
				`CBX_ADDR_FLAGS: rdmux_c = {24'h00_0000, flags_reg};
				`CBX_ADDR_PC: rdmux_c = {16'h0000, pc_reg};
				`CBX_ADDR_SP: rdmux_c = {16'h0000, sp_reg};
				default: rdmux_c = 32'h0000_0000; // unmapped reads zero
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_reg <= 32'h0000_0000;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			hrdata_reg <= rdmux_c;
		end
	end

	// --------------------------------
	// decode: length, branch test, illegal forms
	// --------------------------------
	always_comb begin
		len_c = `CBX_LEN_1;
		take_c = 1'b0;
		bad_c = 1'b0;
		case (op)
			cbx_pkg::CBX_OP_NOP, cbx_pkg::CBX_OP_SLEEP, cbx_pkg::CBX_OP_WDR,
			cbx_pkg::CBX_OP_BREAK: len_c = `CBX_LEN_1;
			cbx_pkg::CBX_OP_BR_FSET: take_c = flags_reg[ins_reg.sel];
			cbx_pkg::CBX_OP_BR_FCLR: take_c = !flags_reg[ins_reg.sel];
			cbx_pkg::CBX_OP_BR_GE: take_c = !(flags_reg[`CBX_FLAG_N] ^ flags_reg[`CBX_FLAG_V]);
			cbx_pkg::CBX_OP_BR_LT: take_c = flags_reg[`CBX_FLAG_N] ^ flags_reg[`CBX_FLAG_V];
			cbx_pkg::CBX_OP_LSL, cbx_pkg::CBX_OP_LSR, cbx_pkg::CBX_OP_ROL, cbx_pkg::CBX_OP_ROR,
			cbx_pkg::CBX_OP_ASR, cbx_pkg::CBX_OP_BST, cbx_pkg::CBX_OP_BLD,
			cbx_pkg::CBX_OP_FSET, cbx_pkg::CBX_OP_FCLR: len_c = `CBX_LEN_1;
			cbx_pkg::CBX_OP_IO_SET, cbx_pkg::CBX_OP_IO_CLR, cbx_pkg::CBX_OP_LD_DIR,
			cbx_pkg::CBX_OP_ST_DIR, cbx_pkg::CBX_OP_PUSH, cbx_pkg::CBX_OP_POP,
			cbx_pkg::CBX_OP_PM_WRITE: len_c = `CBX_LEN_2;
			cbx_pkg::CBX_OP_LD_IND, cbx_pkg::CBX_OP_ST_IND: begin
				len_c = `CBX_LEN_2;
				bad_c = (ins_reg.sel[1:0] == 2'h3) || (ins_reg.mode == 2'h3);
			end
			cbx_pkg::CBX_OP_LD_DISP, cbx_pkg::CBX_OP_ST_DISP: begin
				len_c = `CBX_LEN_2;
				bad_c = (ins_reg.sel[1:0] != `CBX_PTR_Y) && (ins_reg.sel[1:0] != `CBX_PTR_Z);
			end
			cbx_pkg::CBX_OP_PM_READ: begin
				len_c = `CBX_LEN_3;
				bad_c = (ins_reg.mode == 2'h3);
			end
			default: bad_c = 1'b1; // unknown code
		endcase
		if (take_c) begin
			len_c = `CBX_LEN_2; // taken branch costs a second cycle
		end
		if (bad_c) begin
			len_c = `CBX_LEN_1;
		end
	end

	// --------------------------------
	// operands and effective address
	// --------------------------------
	always_comb begin
		case (ins_reg.sel[1:0])
			`CBX_PTR_X: pidx = `CBX_R_XL;
			`CBX_PTR_Y: pidx = `CBX_R_YL;
			default: pidx = `CBX_R_ZL;
		endcase
		if (op == cbx_pkg::CBX_OP_PM_READ || op == cbx_pkg::CBX_OP_PM_WRITE) begin
			pidx = `CBX_R_ZL; // program memory always through z
		end
	end

	assign ptr_val = {gpr_reg[pidx + 5'd1], gpr_reg[pidx]};
	assign rd_val = gpr_reg[ins_reg.rd];
	assign bmask = 8'h01 << ins_reg.sel;

	always_comb begin
		case (op)
			cbx_pkg::CBX_OP_LD_IND, cbx_pkg::CBX_OP_ST_IND:
				ea_c = (ins_reg.mode == `CBX_MODE_DEC) ? ptr_val - 16'h0001 : ptr_val;
			cbx_pkg::CBX_OP_LD_DISP, cbx_pkg::CBX_OP_ST_DISP:
				ea_c = ptr_val + {10'h000, ins_reg.imm[5:0]};
			cbx_pkg::CBX_OP_LD_DIR, cbx_pkg::CBX_OP_ST_DIR: ea_c = ins_reg.imm;
			cbx_pkg::CBX_OP_POP: ea_c = sp_reg + 16'h0001;
			default: ea_c = sp_reg;
		endcase
	end

	cbx_shift_unit u_shift (
		.op(op),
		.value(rd_val),
		.cin(flags_reg[`CBX_FLAG_C]),
		.result(sh_res),
		.c_out(sh_c),
		.z_out(sh_z),
		.n_out(sh_n),
		.v_out(sh_v)
	);

	// --------------------------------
	// outside requests
	// --------------------------------
	// data memory and stack accesses issue in the first cycle
	always_comb begin
		dmem_req = '0;
		dmem_req.addr = ea_c;
		dmem_req.wdata = rd_val;
		if (step0 && !bad_c) begin
			case (op)
				cbx_pkg::CBX_OP_LD_IND, cbx_pkg::CBX_OP_LD_DISP, cbx_pkg::CBX_OP_LD_DIR,
				cbx_pkg::CBX_OP_POP: dmem_req.re = 1'b1;
				cbx_pkg::CBX_OP_ST_IND, cbx_pkg::CBX_OP_ST_DISP, cbx_pkg::CBX_OP_ST_DIR,
				cbx_pkg::CBX_OP_PUSH: dmem_req.we = 1'b1;
				default: dmem_req.re = 1'b0;
			endcase
		end
	end

	// io read in the first cycle, modified write in the second
	always_comb begin
		io_req = '0;
		io_req.addr = ins_reg.imm[5:0];
		io_req.wdata = (op == cbx_pkg::CBX_OP_IO_SET) ? (io_rdata | bmask) : (io_rdata & ~bmask);
		if (busy && (op == cbx_pkg::CBX_OP_IO_SET || op == cbx_pkg::CBX_OP_IO_CLR)) begin
			io_req.re = step0;
			io_req.we = (step_reg == 2'd1);
		end
	end

	// program memory word access through z
	always_comb begin
		pm_req = '0;
		pm_req.addr = ptr_val[15:1];
		pm_req.wdata = {gpr_reg[`CBX_R_R1], gpr_reg[`CBX_R_R0]};
		if (step0 && !bad_c) begin
			pm_req.re = (op == cbx_pkg::CBX_OP_PM_READ);
			pm_req.we = (op == cbx_pkg::CBX_OP_PM_WRITE);
		end
	end

	// side strobes for power, watchdog and debug units
	assign sleep_req = step0 && (op == cbx_pkg::CBX_OP_SLEEP);
	assign wdr_pulse = step0 && (op == cbx_pkg::CBX_OP_WDR);
	assign break_pulse = step0 && (op == cbx_pkg::CBX_OP_BREAK);

	// --------------------------------
	// results at the last cycle
	// --------------------------------
	always_comb begin
		gwe_c = 1'b0;
		gwa_c = ins_reg.rd;
		gwd_c = sh_res;
		pwe_c = 1'b0;
		pwd_c = ptr_val;
		flags_next = flags_reg;
		sp_next = sp_reg;
		if (last_c && !bad_c) begin
			case (op)
				cbx_pkg::CBX_OP_LSL, cbx_pkg::CBX_OP_LSR, cbx_pkg::CBX_OP_ROL,
				cbx_pkg::CBX_OP_ROR, cbx_pkg::CBX_OP_ASR: begin
					gwe_c = 1'b1;
					flags_next[`CBX_FLAG_C] = sh_c;
					flags_next[`CBX_FLAG_Z] = sh_z;
					flags_next[`CBX_FLAG_N] = sh_n;
					flags_next[`CBX_FLAG_V] = sh_v;
				end
				cbx_pkg::CBX_OP_BST: flags_next[`CBX_FLAG_T] = rd_val[ins_reg.sel];
				cbx_pkg::CBX_OP_BLD: begin
					gwe_c = 1'b1;
					gwd_c = flags_reg[`CBX_FLAG_T] ? (rd_val | bmask) : (rd_val & ~bmask);
				end
				cbx_pkg::CBX_OP_FSET: flags_next[ins_reg.sel] = 1'b1;
				cbx_pkg::CBX_OP_FCLR: flags_next[ins_reg.sel] = 1'b0;
				cbx_pkg::CBX_OP_LD_IND, cbx_pkg::CBX_OP_ST_IND: begin
					gwe_c = (op == cbx_pkg::CBX_OP_LD_IND);
					gwd_c = dmem_rdata;
					pwe_c = (ins_reg.mode != `CBX_MODE_PLAIN);
					pwd_c = (ins_reg.mode == `CBX_MODE_INC) ? ptr_val + 16'h0001 : ea_c;
				end
				cbx_pkg::CBX_OP_LD_DISP, cbx_pkg::CBX_OP_LD_DIR: begin
					gwe_c = 1'b1;
					gwd_c = dmem_rdata;
				end
				cbx_pkg::CBX_OP_POP: begin
					gwe_c = 1'b1;
					gwd_c = dmem_rdata;
					sp_next = ea_c;
				end
				cbx_pkg::CBX_OP_PUSH: sp_next = sp_reg - 16'h0001;
				cbx_pkg::CBX_OP_PM_READ: begin
					gwe_c = 1'b1;
					if (ins_reg.mode == `CBX_MODE_PLAIN) begin
						gwa_c = `CBX_R_R0;
					end
					gwd_c = ptr_val[0] ? pm_hold_reg[15:8] : pm_hold_reg[7:0];
					pwe_c = (ins_reg.mode == 2'h2);
					pwd_c = ptr_val + 16'h0001;
				end
				default: gwe_c = 1'b0;
			endcase
		end
	end

	// --------------------------------
	// sequencer
	// --------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_reg <= cbx_pkg::CBX_ST_IDLE;
			step_reg <= 2'd0;
			ins_reg <= '0;
			err_reg <= 1'b0;
			cyc_reg <= 2'd0;
		end else begin
			unique case (st_reg)
				cbx_pkg::CBX_ST_IDLE: begin
					if (wr_ok && wr_addr_reg == `CBX_ADDR_INSTR) begin
						ins_reg <= hwdata;
						st_reg <= cbx_pkg::CBX_ST_EXEC;
						step_reg <= 2'd0;
					end
				end
				cbx_pkg::CBX_ST_EXEC: begin
					if (last_c) begin
						st_reg <= cbx_pkg::CBX_ST_IDLE;
						err_reg <= bad_c;
						cyc_reg <= len_c;
					end else begin
						step_reg <= step_reg + 2'd1;
					end
				end
			endcase
		end
	end

	// program memory word held between fetch and write-back
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pm_hold_reg <= 16'h0000;
		end else if (busy && step_reg == 2'd1) begin
			pm_hold_reg <= pm_rdata;
		end
	end

	// --------------------------------
	// architectural state
	// --------------------------------
	// register file: bus writes when idle, pointer then data write-back
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < 32; i++) begin
				gpr_reg[i] <= 8'h00;
			end
		end else begin
			if (wr_ok && wr_addr_reg >= `CBX_ADDR_GPR) begin
				gpr_reg[wr_addr_reg[6:2]] <= hwdata[7:0];
			end
			if (pwe_c) begin
				gpr_reg[pidx] <= pwd_c[7:0];
				gpr_reg[pidx + 5'd1] <= pwd_c[15:8];
			end
			if (gwe_c) begin
				gpr_reg[gwa_c] <= gwd_c;
			end
		end
	end

	// status_flags
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags_reg <= `CBX_FLAGS_RST;
		end else if (wr_ok && wr_addr_reg == `CBX_ADDR_FLAGS) begin
			flags_reg <= hwdata[7:0];
		end else begin
			flags_reg <= flags_next; // branches and transfers keep flags
		end
	end

	// program counter: relative jump with a signed offset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pc_reg <= `CBX_PC_RST;
		end else if (wr_ok && wr_addr_reg == `CBX_ADDR_PC) begin
			pc_reg <= hwdata[15:0];
		end else if (last_c) begin
			if (take_c && !bad_c) begin
				pc_reg <= pc_reg + {{9{ins_reg.imm[6]}}, ins_reg.imm[6:0]} + 16'h0001;
			end else begin
				pc_reg <= pc_reg + 16'h0001;
			end
		end
	end

	// stack pointer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sp_reg <= `CBX_SP_RST;
		end else if (wr_ok && wr_addr_reg == `CBX_ADDR_SP) begin
			sp_reg <= hwdata[15:0];
		end else begin
			sp_reg <= sp_next;
		end
	end

endmodule

// File: sim/cbx_mem_model.sv
// data, io and program memory model on the far side of the execution unit
`timescale 1ns/10ps
module cbx_mem_model (
	input logic hclk,
	input cbx_pkg::cbx_mem_req_s dmem_req,
	output logic [7:0] dmem_rdata,
	input cbx_pkg::cbx_io_req_s io_req,
	output logic [7:0] io_rdata,
	input cbx_pkg::cbx_pm_req_s pm_req,
	output logic [15:0] pm_rdata
);
	logic [7:0] dmem [256];
	logic [7:0] io [64];
	logic [15:0] pm [16];
	logic io_hold;
	// known read lines before the first access
	initial begin
		dmem_rdata = 8'h00;
		io_rdata = 8'h00;
		pm_rdata = 16'h0000;
		io_hold = 1'b0;
	end
	// reads answer one cycle late, stale lines show the inverse, io only after holding one more cycle
	always @(posedge hclk) begin
		dmem_rdata <= dmem_req.re ? dmem[dmem_req.addr[7:0]] : ~dmem_rdata;
		pm_rdata <= pm_req.re ? pm[pm_req.addr[3:0]] : ~pm_rdata;
		io_hold <= io_req.re;
		if (io_req.re) begin
			io_rdata <= io[io_req.addr];
		end else if (!io_hold) begin
			io_rdata <= ~io_rdata;
		end
	end
	// writes land at the clock edge
	always @(posedge hclk) begin
		if (dmem_req.we) begin
			dmem[dmem_req.addr[7:0]] <= dmem_req.wdata;
		end
		if (io_req.we) begin
			io[io_req.addr] <= io_req.wdata;
		end
		if (pm_req.we) begin
			pm[pm_req.addr[3:0]] <= pm_req.wdata;
		end
	end
endmodule

// File: sim/cbx_core_chk.sv
// port assertions for the execution unit
`timescale 1ns/10ps
module cbx_core_chk (
	input logic hclk,
	input logic hresetn,
	input logic hreadyout,
	input logic hresp,
	input cbx_pkg::cbx_mem_req_s dmem_req,
	input cbx_pkg::cbx_io_req_s io_req,
	input logic [7:0] io_rdata,
	input cbx_pkg::cbx_pm_req_s pm_req,
	input logic sleep_req,
	input logic wdr_pulse,
	input logic break_pulse
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ------------------------------
	// assertions
	// ------------------------------
	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	io_rmw_a: assert property (io_req.re |=> io_req.we && io_req.addr == $past(io_req.addr))
		else $error("io read not followed by write");
	io_one_bit_a: assert property (io_req.we |-> $countones(io_req.wdata ^ io_rdata) <= 1)
		else $error("io write changed more than one bit");
	pm_gap_a: assert property (pm_req.re |=> !pm_req.re [*2])
		else $error("program read repeated too soon");
	dmem_idle_a: assert property (dmem_req.re |=> !(dmem_req.re || dmem_req.we))
		else $error("data access in load second cycle");
	store_once_a: assert property (dmem_req.we |=> !dmem_req.we)
		else $error("store strobe longer than one cycle");
	one_space_a: assert property ($onehot0({dmem_req.re | dmem_req.we,
		io_req.re | io_req.we, pm_req.re | pm_req.we}))
		else $error("two memory spaces accessed at once");
	wdr_pulse_a: assert property (wdr_pulse |=> !wdr_pulse)
		else $error("restart strobe too long");
	sleep_pulse_a: assert property ($rose(sleep_req) |=> $fell(sleep_req))
		else $error("sleep strobe too long");
	break_alone_a: assert property (break_pulse |-> !(wdr_pulse || sleep_req || dmem_req.we))
		else $error("break strobe with other effects");
	io_cov: cover property (io_req.we);
	pm_cov: cover property (pm_req.re);
	brk_cov: cover property (break_pulse);
endmodule

bind cbx_core cbx_core_chk chk_u (
	.hclk(hclk),
	.hresetn(hresetn),
	.hreadyout(hreadyout),
	.hresp(hresp),
	.dmem_req(dmem_req),
	.io_req(io_req),
	.io_rdata(io_rdata),
	.pm_req(pm_req),
	.sleep_req(sleep_req),
	.wdr_pulse(wdr_pulse),
	.break_pulse(break_pulse)
);

// File: sim/cbx_core_tb.sv
// self-checking bench for the execution unit
`timescale 1ns/10ps
`include "cbx_defines.svh"
module cbx_core_tb;
	typedef struct {
		logic [4:0] op;
		logic [2:0] sel;
		logic [15:0] imm;
		logic [7:0] ri;
		logic [7:0] fi;
		logic [7:0] re;
		logic [7:0] fe;
		logic [15:0] pc;
		logic [1:0] cy;
	} cbx_row_s;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic sleep_req, wdr_pulse, break_pulse;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, s;
	logic [7:0] dmem_rdata, io_rdata;
	logic [15:0] pm_rdata;
	cbx_pkg::cbx_mem_req_s dmem_req;
	cbx_pkg::cbx_io_req_s io_req;
	cbx_pkg::cbx_pm_req_s pm_req;
	int fails = 0;
	int comparisons = 0;
	int pulses = 0;
	cbx_row_s rows [21];
	assign hready = hreadyout;
	// side strobes weighted and counted where they are settled
	always @(negedge hclk) pulses += sleep_req + 2 * wdr_pulse + 4 * break_pulse;
	// bus clock
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end
	cbx_core dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dmem_req(dmem_req),
		.dmem_rdata(dmem_rdata), .io_req(io_req), .io_rdata(io_rdata), .pm_req(pm_req),
		.pm_rdata(pm_rdata), .sleep_req(sleep_req), .wdr_pulse(wdr_pulse),
		.break_pulse(break_pulse));
	cbx_mem_model mem_u (.hclk(hclk), .dmem_req(dmem_req), .dmem_rdata(dmem_rdata),
		.io_req(io_req), .io_rdata(io_rdata), .pm_req(pm_req), .pm_rdata(pm_rdata));
	// ------------------------------
	// bus and check tasks
	// ------------------------------
	task automatic print_verdict();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, s);
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic chkr(input string n, input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0, s);
		chk(n, e, s);
	endtask
	// poll busy, then compare cycle count and error bit
	task automatic done(input logic [1:0] cy, input logic e);
		s = 32'h1;
		for (int i = 0; i < 20 && s[0] !== 1'b0; i++) xfer(1'b0, `CBX_ADDR_STATUS, 32'h0, s);
		chk("status", {26'h0, cy, 2'h0, e, 1'b0}, s);
	endtask
	task automatic exec(input logic [31:0] w, input logic [1:0] cy, input logic e);
		wr(`CBX_ADDR_INSTR, w);
		done(cy, e);
	endtask
	function automatic logic [31:0] mk(input logic [4:0] op, input logic [4:0] rd,
		input logic [2:0] sel, input logic [1:0] md, input logic [15:0] imm);
		return {imm, 1'b0, md, sel, rd, op};
	endfunction
	// hang guard
	initial begin
		repeat (6000) @(posedge hclk);
		fails++;
		print_verdict();
	end
	// ------------------------------
	// main sequence
	// ------------------------------
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		htrans = 2'h0;
		hwrite = 1'b0;
		haddr = 32'h0;
		hwdata = 32'h0;
		rows = '{'{5'h0a, 3'h0, 16'h0, 8'h81, 8'h10, 8'h02, 8'h19, 16'h11, 2'h1},
			'{5'h0b, 3'h0, 16'h0, 8'h01, 8'h00, 8'h00, 8'h0b, 16'h11, 2'h1},
			'{5'h0c, 3'h0, 16'h0, 8'h80, 8'h01, 8'h01, 8'h09, 16'h11, 2'h1},
			'{5'h0d, 3'h0, 16'h0, 8'h01, 8'h01, 8'h80, 8'h05, 16'h11, 2'h1},
			'{5'h0e, 3'h0, 16'h0, 8'h82, 8'h00, 8'hc1, 8'h0c, 16'h11, 2'h1},
			'{5'h0f, 3'h3, 16'h0, 8'h08, 8'h00, 8'h08, 8'h40, 16'h11, 2'h1},
			'{5'h10, 3'h0, 16'h0, 8'h00, 8'h40, 8'h01, 8'h40, 16'h11, 2'h1},
			'{5'h12, 3'h2, 16'h0, 8'h00, 8'hff, 8'h00, 8'hfb, 16'h11, 2'h1},
			'{5'h04, 3'h0, 16'h5, 8'h00, 8'h01, 8'h00, 8'h01, 16'h16, 2'h2},
			'{5'h05, 3'h0, 16'h5, 8'h00, 8'h01, 8'h00, 8'h01, 16'h11, 2'h1},
			'{5'h04, 3'h2, 16'h78, 8'h00, 8'h04, 8'h00, 8'h04, 16'h09, 2'h2},
			'{5'h04, 3'h3, 16'h7f, 8'h00, 8'h08, 8'h00, 8'h08, 16'h10, 2'h2},
			'{5'h06, 3'h0, 16'h2, 8'h00, 8'h0c, 8'h00, 8'h0c, 16'h13, 2'h2},
			'{5'h07, 3'h0, 16'h7e, 8'h00, 8'h04, 8'h00, 8'h04, 16'h0f, 2'h2},
			'{5'h06, 3'h0, 16'h2, 8'h00, 8'h04, 8'h00, 8'h04, 16'h11, 2'h1},
			'{5'h04, 3'h5, 16'h3, 8'h00, 8'h00, 8'h00, 8'h00, 16'h11, 2'h1},
			'{5'h05, 3'h6, 16'h3, 8'h00, 8'h00, 8'h00, 8'h00, 16'h14, 2'h2},
			'{5'h00, 3'h0, 16'h0, 8'h33, 8'ha5, 8'h33, 8'ha5, 16'h11, 2'h1},
			'{5'h01, 3'h0, 16'h0, 8'h33, 8'h5a, 8'h33, 8'h5a, 16'h11, 2'h1},
			'{5'h02, 3'h0, 16'h0, 8'h33, 8'h3c, 8'h33, 8'h3c, 16'h11, 2'h1},
			'{5'h03, 3'h0, 16'h0, 8'h33, 8'hc3, 8'h33, 8'hc3, 16'h11, 2'h1}};
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		chkr("flags", `CBX_ADDR_FLAGS, 32'h0);
		chkr("pc", `CBX_ADDR_PC, 32'h0);
		chkr("sp", `CBX_ADDR_SP, 32'h00ff);
		chkr("unmapped", 8'h40, 32'h0);
		// table of one-register, flag, branch, nop and strobe cases on r5 from pc 0x10
		foreach (rows[i]) begin
			wr(8'h94, {24'h0, rows[i].ri});
			wr(`CBX_ADDR_FLAGS, {24'h0, rows[i].fi});
			wr(`CBX_ADDR_PC, 32'h10);
			exec(mk(rows[i].op, 5'd5, rows[i].sel, 2'h0, rows[i].imm), rows[i].cy, 1'b0);
			chkr("result", 8'h94, {24'h0, rows[i].re});
			chkr("flags", `CBX_ADDR_FLAGS, {24'h0, rows[i].fe});
			chkr("pc", `CBX_ADDR_PC, {16'h0, rows[i].pc});
		end
		chk("strobes", 32'h7, pulses);
		// every flag set on its own
		for (int f = 0; f < 8; f++) begin
			wr(`CBX_ADDR_FLAGS, 32'h0);
			exec(mk(5'h11, 5'd0, f[2:0], 2'h0, 16'h0), 2'h1, 1'b0);
			chkr("flag set", `CBX_ADDR_FLAGS, 32'h1 << f);
		end
		// memory transfers with flags held at 0x3c
		wr(`CBX_ADDR_FLAGS, 32'h3c);
		wr(8'he8, 32'h20);
		wr(8'hec, 32'h0);
		mem_u.dmem[8'h20] = 8'h5a;
		exec(mk(5'h13, 5'd5, 3'h0, 2'h1, 16'h0), 2'h2, 1'b0);
		chkr("load", 8'h94, 32'h5a);
		chkr("x", 8'he8, 32'h21);
		wr(8'hf0, 32'h31);
		wr(8'hf4, 32'h0);
		wr(8'h94, 32'h77);
		exec(mk(5'h14, 5'd5, 3'h1, 2'h2, 16'h0), 2'h2, 1'b0);
		chk("store", 32'h77, {24'h0, mem_u.dmem[8'h30]});
		chkr("y", 8'hf0, 32'h30);
		wr(8'hf8, 32'h40);
		wr(8'hfc, 32'h0);
		mem_u.dmem[8'h43] = 8'h3c;
		exec(mk(5'h15, 5'd6, 3'h2, 2'h0, 16'h3), 2'h2, 1'b0);
		chkr("displaced", 8'h98, 32'h3c);
		chkr("z", 8'hf8, 32'h40);
		exec(mk(5'h16, 5'd5, 3'h1, 2'h0, 16'h4), 2'h2, 1'b0);
		chk("st disp", 32'h77, {24'h0, mem_u.dmem[8'h34]});
		exec(mk(5'h15, 5'd6, 3'h0, 2'h0, 16'h3), 2'h1, 1'b1);
		exec(mk(5'h13, 5'd6, 3'h3, 2'h0, 16'h0), 2'h1, 1'b1);
		exec(mk(5'h18, 5'd5, 3'h0, 2'h0, 16'h50), 2'h2, 1'b0);
		chk("direct", 32'h77, {24'h0, mem_u.dmem[8'h50]});
		mem_u.dmem[8'h51] = 8'h96;
		exec(mk(5'h17, 5'd6, 3'h0, 2'h0, 16'h51), 2'h2, 1'b0);
		chkr("direct load", 8'h98, 32'h96);
		mem_u.io[5] = 8'h10;
		exec(mk(5'h08, 5'd0, 3'h2, 2'h0, 16'h5), 2'h2, 1'b0);
		chk("io set", 32'h14, {24'h0, mem_u.io[5]});
		exec(mk(5'h09, 5'd0, 3'h4, 2'h0, 16'h5), 2'h2, 1'b0);
		chk("io clear", 32'h04, {24'h0, mem_u.io[5]});
		// program read with a flag write refused while busy
		wr(8'hf8, 32'h3);
		mem_u.pm[1] = 16'hbeef;
		wr(`CBX_ADDR_INSTR, mk(5'h19, 5'd5, 3'h0, 2'h2, 16'h0));
		wr(`CBX_ADDR_FLAGS, 32'hff);
		done(2'h3, 1'b0);
		chkr("pm byte", 8'h94, 32'hbe);
		chkr("z inc", 8'hf8, 32'h04);
		wr(8'h80, 32'h11);
		wr(8'h84, 32'h22);
		exec(mk(5'h1a, 5'd0, 3'h0, 2'h0, 16'h0), 2'h2, 1'b0);
		chk("pm write", 32'h2211, {16'h0, mem_u.pm[2]});
		wr(8'hf8, 32'h5);
		exec(mk(5'h19, 5'd5, 3'h0, 2'h0, 16'h0), 2'h3, 1'b0);
		chkr("pm r0", 8'h80, 32'h22);
		exec(mk(5'h1b, 5'd5, 3'h0, 2'h0, 16'h0), 2'h2, 1'b0);
		chk("push", 32'hbe, {24'h0, mem_u.dmem[8'hff]});
		chkr("sp", `CBX_ADDR_SP, 32'hfe);
		exec(mk(5'h1c, 5'd6, 3'h0, 2'h0, 16'h0), 2'h2, 1'b0);
		chkr("pop", 8'h98, 32'hbe);
		chkr("sp", `CBX_ADDR_SP, 32'hff);
		chkr("flags", `CBX_ADDR_FLAGS, 32'h3c);
		// reset in mid-run returns the state to its reset values
		hresetn <= 1'b0;
		@(posedge hclk);
		chk("rst hrdata", 32'h0, hrdata);
		hresetn <= 1'b1;
		chkr("rst pc", `CBX_ADDR_PC, 32'h0);
		chkr("rst sp", `CBX_ADDR_SP, 32'h00ff);
		chkr("rst r6", 8'h98, 32'h0);
		print_verdict();
	end
endmodule
